// [difd_defines.svh]
/*
  timing counts, function codes and widths for the drive input function decoder.
  assumes a 100 MHz system clock; included by the package and the decoder.
*/
`ifndef DIFD_DEFINES_SVH
`define DIFD_DEFINES_SVH
`define DIFD_CLK_MHZ 100
`define DIFD_JOG_CONFLICT_MS 500
`define DIFD_JOG_CONFLICT_CYC (`DIFD_JOG_CONFLICT_MS * 1000 * `DIFD_CLK_MHZ)
`define DIFD_DEBOUNCE_CYC 1000
`define DIFD_FW 16
`define DIFD_FN_3WIRE 5'h00
`define DIFD_FN_SELFHOLD 5'h01
`define DIFD_FN_STEP1 5'h02
`define DIFD_FN_STEP2 5'h03
`define DIFD_FN_STEP3 5'h04
`define DIFD_FN_STEP4 5'h05
`define DIFD_FN_JOGSEL 5'h06
`define DIFD_FN_RAMPSEL 5'h07
`define DIFD_FN_BLOCK_NO 5'h08
`define DIFD_FN_BLOCK_NC 5'h09
`define DIFD_FN_HOLD 5'h0A
`define DIFD_FN_OVHT 5'h0B
`define DIFD_FN_FORWARD_JOG_CMD 5'h0C
`define DIFD_FN_REVERSE_JOG_CMD 5'h0D
`define DIFD_FN_IRST 5'h0E
`define DIFD_FN_PIDOFF 5'h0F
`define DIFD_FN_EXTF_NO 5'h10
`define DIFD_FN_EXTF_NC 5'h11
`define DIFD_FN_AUXEN 5'h12
`define DIFD_FN_DCBRK 5'h14
`define DIFD_FN_LOCAL_OP 5'h17
`define DIFD_FN_LOCAL_TERM 5'h18
`define DIFD_FN_SRC_REMOTE 2'h0
`define DIFD_FN_SRC_PANEL 2'h1
`define DIFD_FN_SRC_TERM 2'h2
`define DIFD_NO_FAULT 3'h0
`endif

// [difd_pkg.sv]
/*
  types for the drive input function decoder.
  assumes difd_defines.svh is on the include path.
*/
`include "difd_defines.svh"
package difd_pkg;
  typedef logic [`DIFD_FW-1:0] difd_freq_t;
  typedef struct packed {
    logic run;
    logic reverse;
    logic out_enable;
    logic coast;
    logic dc_brake;
    logic ramp_hold;
    logic ramp_set2;
    logic zero_freq;
  } difd_run_ctl_t;
  typedef struct packed {
    logic freq_cmd_err;
    logic block_alarm;
    logic overheat;
    logic ext_fault;
    logic [2:0] fault_term;
    logic remote_led;
  } difd_status_t;
  typedef enum logic [2:0] {
    DIFD_ST_STOP,
    DIFD_ST_RUN,
    DIFD_ST_DECEL,
    DIFD_ST_COAST,
    DIFD_ST_FAULT
  } difd_state_t;
endpackage

// [difd_decoder.sv]
/*
  drive input function decoder: debounced terminals into run, frequency and status.
  assumes terminals are asynchronous contacts; settings are static from the same clock.
*/
`timescale 1ns/10ps
`include "difd_defines.svh"
module difd_decoder #(
  parameter int unsigned JOG_CONFLICT_CYC = `DIFD_JOG_CONFLICT_CYC,
  parameter int unsigned DEBOUNCE_CYC = `DIFD_DEBOUNCE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic fwd_term_in,
  input wire logic rev_term_in,
  input wire logic fault_term3_in,
  input wire logic [3:0] multi_term_in,
  input wire logic [4:0] input_function_select_a_in,
  input wire logic [4:0] input_function_select_b_in,
  input wire logic [4:0] input_function_select_c_in,
  input wire logic [4:0] input_function_select_d_in,
  input wire logic [4:0] term3_function_in,
  input wire logic run_source_select_in,
  input wire logic freq_source_select_in,
  input wire logic stop_method_select_in,
  input wire logic analog_input_function_zero_in,
  input wire logic pid_enable_in,
  input wire logic panel_run_in,
  input wire logic panel_reverse_in,
  input wire difd_pkg::difd_freq_t panel_freq_in,
  input wire difd_pkg::difd_freq_t voltage_analog_input_in,
  input wire difd_pkg::difd_freq_t current_analog_input_in,
  input wire difd_pkg::difd_freq_t aux_analog_input_in,
  input wire difd_pkg::difd_freq_t jog_freq_setting_in,
  input wire difd_pkg::difd_freq_t preset_freq_in [16],
  input wire logic decel_active_in,
  input wire logic fault_reset_in,
  output difd_pkg::difd_freq_t freq_ref_out,
  output difd_pkg::difd_run_ctl_t run_ctl_out,
  output difd_pkg::difd_status_t status_out,
  output logic pid_integral_reset_out,
  output logic pid_open_loop_out,
  output logic aux_enable_out
);
  import difd_pkg::*;

  localparam int NT = 7;
  logic [NT-1:0] raw_in;
  logic [NT-1:0] sync1_q, sync2_q, deb_q;
  logic [NT-1:0] prev_q;
  logic [15:0] deb_cnt_q [NT];
  assign raw_in = {multi_term_in, fault_term3_in, rev_term_in, fwd_term_in};

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // a change must hold for the whole window, so contact bounce gives one edge
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      deb_q <= '0;
      prev_q <= '0;
      for (int i = 0; i < NT; i++) begin
        deb_cnt_q[i] <= '0;
      end
    end else begin
      prev_q <= sync2_q;
      for (int i = 0; i < NT; i++) begin
        if (sync2_q[i] != prev_q[i] || sync2_q[i] == deb_q[i]) begin
          deb_cnt_q[i] <= '0;
        end else if (deb_cnt_q[i] == 16'(DEBOUNCE_CYC - 1)) begin
          deb_q[i] <= sync2_q[i];
          deb_cnt_q[i] <= '0;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  logic fwd, rev;
  logic [3:0] mt;
  logic [4:0] fsel [4];
  assign fwd = deb_q[0];
  assign rev = deb_q[1];
  assign mt = deb_q[6:3];
  assign fsel[0] = input_function_select_a_in;
  assign fsel[1] = input_function_select_b_in;
  assign fsel[2] = input_function_select_c_in;
  assign fsel[3] = input_function_select_d_in;

  function automatic logic fn_on(input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (fsel[k] == code && mt[k]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic fn_set(input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (fsel[k] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [3:0] step_idx;
  logic jog_sel, forward_jog_cmd, reverse_jog_cmd, blk, hold, ovht, dcb, loc_op, loc_term;
  logic ext_flt;
  logic [2:0] flt_term;
  always_comb begin
    step_idx = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (fsel[k] == (5'(`DIFD_FN_STEP1) + 5'(k)) && mt[k]) begin
        step_idx[k] = 1'b1;
      end
    end
  end
  // a process, not assigns: the functions read fsel and mt, which args alone would not track
  always_comb begin
    jog_sel = fn_on(`DIFD_FN_JOGSEL);
    forward_jog_cmd = fn_on(`DIFD_FN_FORWARD_JOG_CMD);
    reverse_jog_cmd = fn_on(`DIFD_FN_REVERSE_JOG_CMD);
    blk = fn_on(`DIFD_FN_BLOCK_NO) | (fn_set(`DIFD_FN_BLOCK_NC) & ~fn_on(`DIFD_FN_BLOCK_NC));
    hold = fn_on(`DIFD_FN_HOLD);
    ovht = fn_on(`DIFD_FN_OVHT);
    dcb = fn_on(`DIFD_FN_DCBRK);
    loc_op = fn_on(`DIFD_FN_LOCAL_OP);
    loc_term = fn_on(`DIFD_FN_LOCAL_TERM);
  end

  // terminal 3 is fault-only; codes 3..7 name terminals 3, 5, 6, 7, 8
  always_comb begin
    ext_flt = 1'b0;
    flt_term = `DIFD_NO_FAULT;
    for (int k = 3; k >= 0; k--) begin
      if ((fsel[k] == `DIFD_FN_EXTF_NO && mt[k]) || (fsel[k] == `DIFD_FN_EXTF_NC && !mt[k])) begin
        ext_flt = 1'b1;
        flt_term = 3'(k + 4);
      end
    end
    if ((term3_function_in == `DIFD_FN_EXTF_NO && deb_q[2])
        || (term3_function_in == `DIFD_FN_EXTF_NC && !deb_q[2])) begin
      ext_flt = 1'b1;
      flt_term = 3'h3;
    end
  end

  logic [1:0] src_q;
  logic [1:0] src_want;
  logic two_wire;
  assign src_want = loc_op ? `DIFD_FN_SRC_PANEL : (loc_term ? `DIFD_FN_SRC_TERM : `DIFD_FN_SRC_REMOTE);
  assign two_wire = fsel[0] != `DIFD_FN_3WIRE && fsel[0] != `DIFD_FN_SELFHOLD;

  logic jog_any, jog_conflict, dir_conflict;
  logic term_run, term_rev, run_req, rev_req;
  logic [31:0] jog_cnt_q;
  logic jog_stop_q;
  // both jogs keep jogging until the conflict window runs out
  assign jog_any = (forward_jog_cmd | reverse_jog_cmd) & !jog_stop_q;
  assign dir_conflict = two_wire & fwd & rev;
  assign term_run = two_wire ? ((fwd ^ rev)) : fwd;
  assign term_rev = two_wire ? rev : 1'b0;
  always_comb begin
    run_req = 1'b0;
    rev_req = 1'b0;
    case (src_q)
      `DIFD_FN_SRC_PANEL: begin
        run_req = panel_run_in;
        rev_req = panel_reverse_in;
      end
      `DIFD_FN_SRC_TERM: begin
        run_req = term_run;
        rev_req = term_rev;
      end
      default: begin
        run_req = run_source_select_in ? term_run : panel_run_in;
        rev_req = run_source_select_in ? term_rev : panel_reverse_in;
      end
    endcase
  end

  assign jog_conflict = forward_jog_cmd & reverse_jog_cmd;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      jog_cnt_q <= '0;
      jog_stop_q <= 1'b0;
    end else if (!jog_conflict) begin
      jog_cnt_q <= '0;
      jog_stop_q <= 1'b0;
    end else if (jog_cnt_q >= JOG_CONFLICT_CYC) begin
      jog_stop_q <= 1'b1;
    end else begin
      jog_cnt_q <= jog_cnt_q + 32'h1;
    end
  end

  difd_state_t st_q;
  logic go;
  assign go = (run_req | jog_any) & !dir_conflict;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st_q <= DIFD_ST_STOP;
    end else begin
      case (st_q)
        DIFD_ST_STOP: if (ext_flt) st_q <= DIFD_ST_FAULT; else if (go) st_q <= DIFD_ST_RUN;
        DIFD_ST_RUN: begin
          if (ext_flt) st_q <= DIFD_ST_FAULT;
          else if (!go && hold) st_q <= DIFD_ST_COAST;
          else if (!go && stop_method_select_in) st_q <= DIFD_ST_COAST;
          else if (!go || (decel_active_in && blk)) st_q <= blk ? DIFD_ST_COAST : DIFD_ST_DECEL;
        end
        DIFD_ST_DECEL: begin
          if (ext_flt) st_q <= DIFD_ST_FAULT;
          else if (blk) st_q <= DIFD_ST_COAST;
          else if (go) st_q <= DIFD_ST_RUN;
          else if (!decel_active_in) st_q <= DIFD_ST_STOP;
        end
        DIFD_ST_COAST: if (ext_flt) st_q <= DIFD_ST_FAULT; else if (!blk && !go) st_q <= DIFD_ST_STOP;
        DIFD_ST_FAULT: if (!ext_flt && fault_reset_in) st_q <= DIFD_ST_STOP;
        default: st_q <= DIFD_ST_STOP;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      src_q <= `DIFD_FN_SRC_REMOTE;
    end else if (src_want != `DIFD_FN_SRC_REMOTE || st_q == DIFD_ST_STOP) begin
      src_q <= src_want;
    end
  end

  difd_freq_t sel_freq, hold_freq_q;
  logic [4:0] idx;
  assign idx = jog_sel ? 5'h10 : {1'b0, step_idx};
  always_comb begin
    sel_freq = preset_freq_in[step_idx];
    if (jog_any || idx == 5'h10) begin
      sel_freq = jog_freq_setting_in;
    end else if (src_q == `DIFD_FN_SRC_PANEL) begin
      sel_freq = panel_freq_in;
    end else if (step_idx == 4'h0 && freq_source_select_in) begin
      sel_freq = (voltage_analog_input_in > current_analog_input_in) ? voltage_analog_input_in
                                                                   : current_analog_input_in;
    end else if (step_idx == 4'h1 && analog_input_function_zero_in && aux_enable_out) begin
      sel_freq = aux_analog_input_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      freq_ref_out <= '0;
      hold_freq_q <= '0;
    end else begin
      if (hold && st_q == DIFD_ST_RUN && !go) begin
        hold_freq_q <= freq_ref_out;
      end
      freq_ref_out <= (st_q == DIFD_ST_COAST || st_q == DIFD_ST_FAULT) ? '0 : sel_freq;
    end
  end

  // ramp hold is passed to the ramp core, which owns the output frequency
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      run_ctl_out <= '0;
    end else begin
      run_ctl_out.run <= (st_q == DIFD_ST_RUN) & go;
      run_ctl_out.reverse <= jog_any ? reverse_jog_cmd : rev_req;
      run_ctl_out.out_enable <= (st_q == DIFD_ST_RUN || st_q == DIFD_ST_DECEL) & !blk & !ext_flt;
      run_ctl_out.coast <= st_q == DIFD_ST_COAST || st_q == DIFD_ST_FAULT;
      run_ctl_out.dc_brake <= dcb & st_q == DIFD_ST_STOP & !go;
      run_ctl_out.ramp_hold <= hold & go;
      run_ctl_out.ramp_set2 <= fn_on(`DIFD_FN_RAMPSEL);
      run_ctl_out.zero_freq <= st_q == DIFD_ST_COAST;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      status_out <= '0;
      pid_integral_reset_out <= 1'b0;
      pid_open_loop_out <= 1'b0;
      aux_enable_out <= 1'b0;
    end else begin
      status_out.freq_cmd_err <= dir_conflict;
      status_out.block_alarm <= blk & st_q != DIFD_ST_STOP;
      status_out.overheat <= ovht;
      status_out.ext_fault <= ext_flt;
      status_out.fault_term <= flt_term;
      status_out.remote_led <= src_q == `DIFD_FN_SRC_REMOTE;
      pid_integral_reset_out <= fn_on(`DIFD_FN_IRST);
      pid_open_loop_out <= fn_on(`DIFD_FN_PIDOFF) | !pid_enable_in;
      aux_enable_out <= (!fn_set(`DIFD_FN_AUXEN) || fn_on(`DIFD_FN_AUXEN)) & !pid_enable_in;
    end
  end
endmodule

// [difd_decoder_asserts.sv]
/*
  concurrent checks on the decoder ports.
  assumes one clock and the sync reset of the decoder.
*/
`timescale 1ns/10ps
module difd_decoder_asserts (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic pid_enable_in,
  input wire difd_pkg::difd_freq_t freq_ref_out,
  input wire difd_pkg::difd_run_ctl_t run_ctl_out,
  input wire difd_pkg::difd_status_t status_out,
  input wire logic pid_open_loop_out,
  input wire logic aux_enable_out
);
  import difd_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  a_err_stops_run: assert property (status_out.freq_cmd_err |-> ##[0:2] !run_ctl_out.run)
    else $error("run kept during command error");
  a_block_cuts_out: assert property (status_out.block_alarm |-> ##[0:2] !run_ctl_out.out_enable)
    else $error("output on during block");
  a_zero_no_out: assert property (run_ctl_out.zero_freq |-> !run_ctl_out.out_enable)
    else $error("output on with zero frequency");
  a_fault_cuts_out: assert property ($rose(status_out.ext_fault) |-> ##[0:2] !run_ctl_out.out_enable)
    else $error("output on in fault");
  a_fault_no_ref: assert property (status_out.ext_fault [*3] |-> freq_ref_out == 16'h0000)
    else $error("reference not zero in fault");
  a_fault_term_code: assert property (status_out.ext_fault |-> status_out.fault_term inside {[3'h3:3'h7]})
    else $error("bad fault terminal code");
  a_brake_when_idle: assert property (run_ctl_out.dc_brake |-> !run_ctl_out.run)
    else $error("brake while running");
  a_remote_when_stop: assert property ($rose(status_out.remote_led) |-> !$past(run_ctl_out.run))
    else $error("remote taken while running");
  a_pid_kills_aux: assert property (pid_enable_in && !pid_open_loop_out |-> ##[0:2] !aux_enable_out)
    else $error("aux on under pid");
  a_reset_outs_idle: assert property ($fell(srst_in) |-> run_ctl_out == 8'h00 && status_out == 8'h00)
    else $error("outputs not idle after reset");
  c_block: cover property (status_out.block_alarm);
  c_fault: cover property (status_out.ext_fault);
  c_brake: cover property (run_ctl_out.dc_brake);
endmodule
bind difd_decoder difd_decoder_asserts i_difd_decoder_asserts (.*);

// [difd_contacts.sv]
/*
  contacts and plc outputs on the decoder terminals.
  assumes the bench sets wanted levels; bounce adds chatter before settling.
*/
`timescale 1ns/10ps
module difd_contacts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bounce_in,
  input wire logic [6:0] want_in,
  output logic [6:0] pins_out
);
  logic [6:0] stable_q;
  logic [1:0] n_q;
  // real contacts chatter, so a one-cycle glitch precedes settling
  always_ff @(posedge clk_in) begin
    if (rst_in || want_in == stable_q) begin
      n_q <= 2'h0;
    end else if (!bounce_in || n_q == 2'h3) begin
      stable_q <= want_in;
    end else begin
      n_q <= n_q + 2'h1;
    end
    if (rst_in) begin
      stable_q <= 7'h00;
    end
  end
  assign pins_out = n_q[0] ? want_in : stable_q;
endmodule

// [tb.sv]
/*
  bench for the input decoder: terminal sequences with expected outputs.
  assumes short debounce and jog counts; contacts model drives terminals.
*/
`timescale 1ns/10ps
module tb;
  import difd_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic bnc = 1'b0;
  logic [6:0] want = 7'h00;
  logic fwd_term_in, rev_term_in, fault_term3_in;
  logic [3:0] multi_term_in;
  logic [4:0] input_function_select_a_in, input_function_select_b_in;
  logic [4:0] input_function_select_c_in, input_function_select_d_in;
  logic [4:0] term3_function_in = 5'h10;
  logic run_source_select_in = 1'b1, freq_source_select_in = 1'b0, stop_method_select_in = 1'b1;
  logic analog_input_function_zero_in = 1'b1, pid_enable_in = 1'b0;
  logic panel_run_in = 1'b0, panel_reverse_in = 1'b0, decel_active_in = 1'b0, fault_reset_in = 1'b0;
  difd_freq_t panel_freq_in = 16'h0AAA, voltage_analog_input_in = 16'h0321;
  difd_freq_t current_analog_input_in = 16'h0456, aux_analog_input_in = 16'h0777;
  difd_freq_t jog_freq_setting_in = 16'h0555;
  difd_freq_t preset_freq_in [16];
  difd_freq_t freq_ref_out;
  difd_run_ctl_t run_ctl_out;
  difd_status_t status_out;
  logic pid_integral_reset_out, pid_open_loop_out, aux_enable_out;
  int errors = 0;
  int n_checks = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  difd_contacts i_difd_contacts (.clk_in(sys_clk_in), .rst_in(srst_in), .bounce_in(bnc), .want_in(want),
    .pins_out({fwd_term_in, rev_term_in, fault_term3_in, multi_term_in}));
  difd_decoder #(.JOG_CONFLICT_CYC(20), .DEBOUNCE_CYC(4)) i_difd_decoder (.*);
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic t(input logic [6:0] v);
    @(posedge sys_clk_in);
    want <= v;
    w(16);
  endtask
  task automatic cfg(input logic [4:0] a, input logic [4:0] b, input logic [4:0] c, input logic [4:0] d);
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    want <= 7'h00;
    pid_enable_in <= 1'b0;
    input_function_select_a_in <= a;
    input_function_select_b_in <= b;
    input_function_select_c_in <= c;
    input_function_select_d_in <= d;
    w(8);
    @(posedge sys_clk_in);
    srst_in <= 1'b0;
    w(16);
  endtask
  task automatic frs;
    @(posedge sys_clk_in);
    fault_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    fault_reset_in <= 1'b0;
    w(4);
  endtask
  task automatic cv(input string n, input difd_freq_t e, input difd_freq_t v);
    n_checks++;
    if (v !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic cb(input string n, input logic e, input logic v);
    n_checks++;
    if (v !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", n, e, v);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    errors++;
    summarize;
  end
  initial begin
    for (int i = 0; i < 16; i++) preset_freq_in[i] = 16'h0100 + 16'(i);
    cfg(5'h02, 5'h03, 5'h04, 5'h05);
    for (int i = 0; i < 16; i++) begin
      t(7'h40 | 7'(i));
      cv("step", (i == 0) ? 16'h0100 : (i == 1) ? 16'h0777 : 16'h0100 + 16'(i), freq_ref_out);
    end
    @(posedge sys_clk_in);
    analog_input_function_zero_in <= 1'b0;
    freq_source_select_in <= 1'b1;
    bnc <= 1'b1;
    t(7'h41);
    cv("step2", 16'h0101, freq_ref_out);
    t(7'h40);
    cv("analog", 16'h0456, freq_ref_out);
    $display("test steps done");
    t(7'h20);
    cb("rev", 1'b1, run_ctl_out.reverse);
    t(7'h60);
    cb("err", 1'b1, status_out.freq_cmd_err);
    cb("run", 1'b0, run_ctl_out.run);
    t(7'h40);
    cb("err", 1'b0, status_out.freq_cmd_err);
    cb("run", 1'b1, run_ctl_out.run);
    t(7'h00);
    cb("run", 1'b0, run_ctl_out.run);
    $display("test two wire done");
    cfg(5'h0C, 5'h0D, 5'h08, 5'h0B);
    t(7'h41);
    cv("jog", 16'h0555, freq_ref_out);
    t(7'h02);
    cb("rev", 1'b1, run_ctl_out.reverse);
    t(7'h03);
    cb("run", 1'b1, run_ctl_out.run);
    w(30);
    cb("run", 1'b0, run_ctl_out.run);
    t(7'h40);
    t(7'h44);
    cb("alarm", 1'b1, status_out.block_alarm);
    cb("oe", 1'b0, run_ctl_out.out_enable);
    t(7'h40);
    cb("oe", 1'b1, run_ctl_out.out_enable);
    @(posedge sys_clk_in);
    decel_active_in <= 1'b1;
    t(7'h44);
    cb("zero", 1'b1, run_ctl_out.zero_freq);
    @(posedge sys_clk_in);
    decel_active_in <= 1'b0;
    t(7'h40);
    cb("run", 1'b0, run_ctl_out.run);
    $display("test jog and block done");
    cfg(5'h07, 5'h0E, 5'h0B, 5'h0A);
    t(7'h43);
    cb("ramp2", 1'b1, run_ctl_out.ramp_set2);
    cb("irst", 1'b1, pid_integral_reset_out);
    t(7'h48);
    cb("hold", 1'b1, run_ctl_out.ramp_hold);
    t(7'h08);
    cb("run", 1'b0, run_ctl_out.run);
    cb("hold", 1'b0, run_ctl_out.ramp_hold);
    $display("test hold done");
    cfg(5'h11, 5'h0B, 5'h0F, 5'h14);
    t(7'h01);
    frs;
    cb("fault", 1'b0, status_out.ext_fault);
    t(7'h43);
    cb("heat", 1'b1, status_out.overheat);
    cb("run", 1'b1, run_ctl_out.run);
    @(posedge sys_clk_in);
    pid_enable_in <= 1'b1;
    t(7'h05);
    cb("heat", 1'b0, status_out.overheat);
    cb("open", 1'b1, pid_open_loop_out);
    t(7'h09);
    cb("open", 1'b0, pid_open_loop_out);
    cb("brake", 1'b1, run_ctl_out.dc_brake);
    t(7'h49);
    cb("brake", 1'b0, run_ctl_out.dc_brake);
    t(7'h40);
    cb("fault", 1'b1, status_out.ext_fault);
    cb("coast", 1'b1, run_ctl_out.coast);
    cv("term", 16'h0004, 16'(status_out.fault_term));
    t(7'h01);
    frs;
    t(7'h11);
    cv("term", 16'h0003, 16'(status_out.fault_term));
    t(7'h01);
    frs;
    $display("test faults done");
    cfg(5'h17, 5'h12, 5'h18, 5'h06);
    cb("led", 1'b1, status_out.remote_led);
    @(posedge sys_clk_in);
    panel_run_in <= 1'b1;
    t(7'h01);
    cb("led", 1'b0, status_out.remote_led);
    cv("panel", 16'h0AAA, freq_ref_out);
    t(7'h00);
    cb("led", 1'b0, status_out.remote_led);
    @(posedge sys_clk_in);
    panel_run_in <= 1'b0;
    t(7'h02);
    cb("led", 1'b1, status_out.remote_led);
    cb("aux", 1'b1, aux_enable_out);
    @(posedge sys_clk_in);
    pid_enable_in <= 1'b1;
    w(4);
    cb("aux", 1'b0, aux_enable_out);
    t(7'h44);
    cb("run", 1'b1, run_ctl_out.run);
    cb("led", 1'b0, status_out.remote_led);
    t(7'h4C);
    cv("jogsel", 16'h0555, freq_ref_out);
    $display("test local done");
    summarize;
  end
endmodule
